// ---- src/qdrb_readback.sv ----
// readback slave of a quad 10-bit converter on the two-wire serial bus
// assumes scl and sda are already synchronous to clk_sys_i, well oversampled
`timescale 1ns/100ps
`default_nettype none
module qdrb_readback
  import qdrb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_pin_high_i,
  input wire logic addr_pin_low_i,
  input wire logic [QDRB_CHANNELS-1:0][QDRB_DATA_BITS-1:0] chan_value_i,
  input wire qdrb_pwrdn_s pwrdn_mode_i,
  output qdrb_ctrl_s ctrl_o,
  output qdrb_out_kind_e out_kind_o,
  output logic busy_o
);

  qdrb_state_e state, next_state;
  logic scl_q, sda_q;
  logic [7:0] shreg, next_shreg;
  logic [2:0] cnt, next_cnt;
  logic got8, next_got8;
  logic [1:0] byte_idx, next_byte_idx;
  qdrb_ctrl_s ctrl, next_ctrl;
  logic [QDRB_DATA_BITS-1:0] snap_val, next_snap_val;
  qdrb_pwrdn_s snap_pd, next_snap_pd;
  logic oe, next_oe;
  qdrb_out_kind_e kind, next_kind;
  logic rise, fall, start_c, stop_c, match, last_byte, lo_next;
  logic [1:0] chan;
  logic [7:0] tx_byte;

  // bus events from the previous and present samples
  assign rise = ~scl_q & scl_i;
  assign fall = scl_q & ~scl_i;
  assign start_c = scl_q & scl_i & sda_q & ~sda_i;
  assign stop_c = scl_q & scl_i & ~sda_q & sda_i;
  assign match = (shreg[7:1] == {QDRB_ADDR_FIXED, addr_pin_high_i, addr_pin_low_i});
  assign chan = {ctrl.channel_select_high, ctrl.channel_select_low};
  // last byte of the sequence depends on the power-down select
  assign last_byte = ctrl.powerdown_select_bit ? (byte_idx == QDRB_IDX_THIRD)
                                               : (byte_idx == QDRB_IDX_SECOND);
  assign lo_next = ctrl.powerdown_select_bit ? (byte_idx == QDRB_IDX_THIRD)
                                             : (byte_idx == QDRB_IDX_SECOND);

  // byte to send at the current sequence position
  always_comb begin
    tx_byte = {snap_val[9:2]};
    if (ctrl.powerdown_select_bit) begin
      unique case (byte_idx)
        QDRB_IDX_FIRST: tx_byte = {snap_pd, QDRB_PD_FILL};
        QDRB_IDX_SECOND: tx_byte = snap_val[9:2];
        default: tx_byte = {snap_val[1:0], 6'h00};
      endcase
    end else if (byte_idx != QDRB_IDX_FIRST) begin
      tx_byte = {snap_val[1:0], 6'h00};
    end
  end

  // protocol sequencer; stop and start win over every state
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_cnt = cnt;
    next_got8 = got8;
    next_byte_idx = byte_idx;
    next_ctrl = ctrl;
    next_snap_val = snap_val;
    next_snap_pd = snap_pd;
    next_oe = oe;
    // decode of the live mode pair; both equal pairs mean open output
    unique case ({pwrdn_mode_i.pwrdn_mode_bit_a, pwrdn_mode_i.pwrdn_mode_bit_b})
      2'h1: next_kind = QDRB_OUT_RES_LOW;
      2'h2: next_kind = QDRB_OUT_RES_HIGH;
      default: next_kind = QDRB_OUT_HIZ;
    endcase
    if (stop_c) begin
      next_state = QDRB_IDLE;
      next_oe = 1'b0;
    end else if (start_c) begin
      // repeated start reopens addressing, as a plain start does
      next_state = QDRB_RX_ADDR;
      next_cnt = 3'h0;
      next_got8 = 1'b0;
      next_oe = 1'b0;
    end else begin
      unique case (state)
        QDRB_IDLE, QDRB_IGNORE: begin
          next_oe = 1'b0;
        end
        QDRB_RX_ADDR, QDRB_RX_CTRL: begin
          if (rise) begin
            next_shreg = {shreg[6:0], sda_i};
            next_cnt = cnt + 3'h1;
            next_got8 = (cnt == QDRB_BIT_LAST);
          end else if (fall && got8) begin
            next_got8 = 1'b0;
            next_cnt = 3'h0;
            if (state == QDRB_RX_CTRL) begin
              next_ctrl = qdrb_ctrl_s'(shreg);
              next_state = QDRB_ACK_CTRL;
              next_oe = 1'b1;
            end else if (!match) begin
              next_state = QDRB_IGNORE;
            end else if (!shreg[0]) begin
              next_state = QDRB_ACK_WADDR;
              next_oe = 1'b1;
            end else begin
              // snapshot so a concurrent write cannot tear the word
              next_state = QDRB_ACK_RADDR;
              next_oe = 1'b1;
              next_snap_val = chan_value_i[chan];
              next_snap_pd = pwrdn_mode_i;
              next_byte_idx = QDRB_IDX_FIRST;
            end
          end
        end
        QDRB_ACK_WADDR: begin
          if (fall) begin
            next_oe = 1'b0;
            next_state = QDRB_RX_CTRL;
          end
        end
        QDRB_ACK_CTRL: begin
          // further written bytes belong to the write path
          if (fall) begin
            next_oe = 1'b0;
            next_state = QDRB_IGNORE;
          end
        end
        QDRB_ACK_RADDR: begin
          if (fall) begin
            next_state = QDRB_TX_BYTE;
            next_shreg = tx_byte;
            next_oe = ~tx_byte[7];
            next_cnt = 3'h0;
          end
        end
        QDRB_TX_BYTE: begin
          // open drain: a one is sent by releasing the line
          if (fall) begin
            if (cnt == QDRB_BIT_LAST) begin
              next_oe = 1'b0;
              next_state = QDRB_RX_MACK;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe = ~shreg[6];
              next_cnt = cnt + 3'h1;
            end
          end
        end
        QDRB_RX_MACK: begin
          if (rise) begin
            if (sda_i || last_byte) begin
              next_state = QDRB_IGNORE;
            end else begin
              next_byte_idx = byte_idx + 2'h1;
              next_got8 = 1'b1;
            end
          end else if (fall && got8) begin
            next_got8 = 1'b0;
            next_state = QDRB_TX_BYTE;
            next_shreg = tx_byte;
            next_oe = ~tx_byte[7];
            next_cnt = 3'h0;
          end
        end
      endcase
    end
  end

  // register stage only
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= QDRB_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      shreg <= QDRB_SHIFT_RST;
      cnt <= 3'h0;
      got8 <= 1'b0;
      byte_idx <= QDRB_IDX_FIRST;
      ctrl <= QDRB_CTRL_RST;
      snap_val <= '0;
      snap_pd <= '0;
      oe <= 1'b0;
      kind <= QDRB_OUT_HIZ;
    end else begin
      state <= next_state;
      scl_q <= scl_i;
      sda_q <= sda_i;
      shreg <= next_shreg;
      cnt <= next_cnt;
      got8 <= next_got8;
      byte_idx <= next_byte_idx;
      ctrl <= next_ctrl;
      snap_val <= next_snap_val;
      snap_pd <= next_snap_pd;
      oe <= next_oe;
      kind <= next_kind;
    end
  end

  // the pin is only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe_o = oe;
  assign ctrl_o = ctrl;
  assign out_kind_o = kind;
  assign busy_o = (state != QDRB_IDLE);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  logic quiet;
  assign quiet = ~start_c & ~stop_c;

  chk_addr_ack: assert property (
    (state == QDRB_RX_ADDR && fall && got8 && match && quiet) |=> oe ##0 (state != QDRB_IGNORE))
    else $error("matching address not acknowledged");
  chk_addr_mismatch: assert property (
    (state == QDRB_RX_ADDR && fall && got8 && !match && quiet) |=> !oe && state == QDRB_IGNORE)
    else $error("foreign address acknowledged");
  chk_ctrl_ack: assert property (
    (state == QDRB_RX_CTRL && fall && got8 && quiet) |=> oe && state == QDRB_ACK_CTRL)
    else $error("control byte not acknowledged");
  chk_ctrl_store: assert property (
    (state == QDRB_RX_CTRL && fall && got8 && quiet) |=> ctrl == $past(shreg))
    else $error("control byte not stored");
  chk_read_start: assert property (
    (state == QDRB_ACK_RADDR && fall && quiet) |=> state == QDRB_TX_BYTE && cnt == 3'h0)
    else $error("read address ack not followed by transmit");
  chk_two_bytes: assert property (
    (state == QDRB_RX_MACK && rise && quiet && !ctrl.powerdown_select_bit
     && byte_idx == QDRB_IDX_SECOND) |=> state == QDRB_IGNORE)
    else $error("more than two bytes sent");
  chk_three_bytes: assert property (
    (state == QDRB_RX_MACK && rise && quiet && !sda_i && ctrl.powerdown_select_bit
     && byte_idx == QDRB_IDX_SECOND) |=> byte_idx == QDRB_IDX_THIRD && got8)
    else $error("third byte missing");
  chk_pd_byte: assert property (
    (state == QDRB_ACK_RADDR && fall && quiet && ctrl.powerdown_select_bit)
    |=> shreg == {snap_pd, QDRB_PD_FILL})
    else $error("power-down byte wrong");
  chk_high_byte: assert property (
    (state == QDRB_ACK_RADDR && fall && quiet && !ctrl.powerdown_select_bit)
    |=> shreg == snap_val[9:2] && oe == !snap_val[9])
    else $error("high data byte wrong");
  chk_low_byte: assert property (
    (state == QDRB_RX_MACK && fall && got8 && quiet && lo_next) |=> shreg[7:6] == snap_val[1:0])
    else $error("low data byte wrong");
  chk_mode_decode: assert property (
    (pwrdn_mode_i == 2'h1) |=> kind == QDRB_OUT_RES_LOW)
    else $error("mode pair decoded wrongly");
  chk_release_mack: assert property (
    (state == QDRB_RX_MACK || state == QDRB_IGNORE || state == QDRB_IDLE) |-> !oe)
    else $error("line driven while not transmitting");

  cov_two_byte: cover property (
    state == QDRB_RX_MACK && rise && sda_i && !ctrl.powerdown_select_bit);
  cov_three_byte: cover property (
    state == QDRB_RX_MACK && rise && sda_i && byte_idx == QDRB_IDX_THIRD);
  cov_foreign: cover property (state == QDRB_RX_ADDR && fall && got8 && !match);

endmodule
`default_nettype wire

// ---- shared/qdrb_pkg.sv ----
// constants, types and states of the quad converter readback slave
// assumes a single system clock and bus pins sampled synchronously
package qdrb_pkg;
  // fixed upper address pattern, then two pin bits, then direction
  localparam logic [4:0] QDRB_ADDR_FIXED = 5'h13;
  localparam int QDRB_BYTE_BITS = 8;
  localparam logic [2:0] QDRB_BIT_LAST = 3'h7;
  localparam int QDRB_DATA_BITS = 10;
  localparam int QDRB_CHANNELS = 4;
  // low six bits of the power-down status byte
  localparam logic [5:0] QDRB_PD_FILL = 6'h3F;
  // readback byte positions
  localparam logic [1:0] QDRB_IDX_FIRST = 2'h0;
  localparam logic [1:0] QDRB_IDX_SECOND = 2'h1;
  localparam logic [1:0] QDRB_IDX_THIRD = 2'h2;
  // reset values
  localparam logic [7:0] QDRB_CTRL_RST = 8'h00;
  localparam logic [7:0] QDRB_SHIFT_RST = 8'h00;

  // control byte layout, msb first
  typedef struct packed {
    logic extended_addr_high;
    logic extended_addr_low;
    logic [1:0] load_mode;
    logic spare;
    logic channel_select_high;
    logic channel_select_low;
    logic powerdown_select_bit;
  } qdrb_ctrl_s;

  // power-down mode pair as stored by the write path
  typedef struct packed {
    logic pwrdn_mode_bit_a;
    logic pwrdn_mode_bit_b;
  } qdrb_pwrdn_s;

  typedef enum logic [1:0] {
    QDRB_OUT_HIZ,
    QDRB_OUT_RES_LOW,
    QDRB_OUT_RES_HIGH
  } qdrb_out_kind_e;

  typedef enum logic [3:0] {
    QDRB_IDLE,
    QDRB_RX_ADDR,
    QDRB_ACK_WADDR,
    QDRB_RX_CTRL,
    QDRB_ACK_CTRL,
    QDRB_ACK_RADDR,
    QDRB_TX_BYTE,
    QDRB_RX_MACK,
    QDRB_IGNORE
  } qdrb_state_e;
endpackage

// ---- tb/qdrb_master.sv ----
// bus master model facing the readback slave
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/100ps
`default_nettype none
module qdrb_master (
  input wire logic clk_sys_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // idle bus, nothing pulled
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // five clocks per half period, enough for the slave's oversampling
  task automatic hp();
    repeat (5) @(negedge clk_sys_i);
  endtask
  // start and repeated start share one shape
  task automatic start_cond();
    sda_low_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_low_o = 1'b1;
    hp();
    scl_o = 1'b0;
  endtask
  // reads end with a stop; a control write runs into a repeated start
  task automatic stop_cond();
    hp();
    sda_low_o = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_low_o = 1'b0;
    hp();
  endtask
  // data set while clock low, sampled late in the high phase
  task automatic xfer(input logic b, output logic r);
    hp();
    sda_low_o = ~b;
    hp();
    scl_o = 1'b1;
    hp();
    r = sda_i;
    scl_o = 1'b0;
  endtask
  // write byte, ack seen as a low ninth bit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], r);
    end
    xfer(1'b1, r);
    ack = ~r;
  endtask
  // read byte; caller leaves the last one unacknowledged
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, d[i]);
    end
    xfer(~mack, r);
  endtask
endmodule
`default_nettype wire

// ---- tb/qdrb_readback_test.sv ----
// self-checking bench for the readback slave
// assumes the package and the master model are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module qdrb_readback_test;
  import qdrb_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin_hi = 1'b0;
  logic pin_lo = 1'b0;
  logic scl, m_low, sda_o, sda_oe_o, busy_o;
  logic [QDRB_CHANNELS-1:0][QDRB_DATA_BITS-1:0] chan = '0;
  qdrb_pwrdn_s pmode = '0;
  qdrb_ctrl_s ctrl_o;
  qdrb_out_kind_e out_kind_o;
  wire logic sda;
  int miscompares = 0;
  int check_count = 0;
  int oe_hits = 0;
  // pull-up: low only while some party pulls
  assign sda = (m_low | (sda_oe_o & ~sda_o)) ? 1'b0 : 1'b1;
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (sda_oe_o === 1'b1) oe_hits++;
  qdrb_master qdrb_master_i (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
  qdrb_readback qdrb_readback_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_pin_high_i(pin_hi), .addr_pin_low_i(pin_lo),
    .chan_value_i(chan), .pwrdn_mode_i(pmode), .ctrl_o(ctrl_o), .out_kind_o(out_kind_o),
    .busy_o(busy_o));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // reset pulse, then idle outputs and a cleared control byte
  task automatic reset_check();
    rst_i = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    `CHK("ctrl reset", QDRB_CTRL_RST, ctrl_o)
    `CHK("busy reset", 1'b0, busy_o)
    `CHK("oe reset", 1'b0, sda_oe_o)
    $display("reset check done");
  endtask
  // decode follows the stored pair; two codes share the open output
  task automatic mode_decode();
    qdrb_out_kind_e ek [4] = '{QDRB_OUT_HIZ, QDRB_OUT_RES_LOW, QDRB_OUT_RES_HIGH, QDRB_OUT_HIZ};
    for (int m = 0; m < 4; m++) begin
      pmode = 2'(m);
      repeat (3) @(negedge clk_sys_i);
      `CHK("out kind", ek[m], out_kind_o)
    end
    $display("mode decode done");
  endtask
  // foreign pin bits: the slave must stay off the data line
  task automatic wrong_addr();
    logic ack;
    oe_hits = 0;
    qdrb_master_i.start_cond();
    qdrb_master_i.wbyte({QDRB_ADDR_FIXED, ~pin_hi, pin_lo, 1'b0}, ack);
    qdrb_master_i.wbyte(8'h01, ack);
    qdrb_master_i.stop_cond();
    `CHK("foreign drive", 0, oe_hits)
    $display("foreign address done");
  endtask
  // whole readback; without the control byte the stored selection applies
  task automatic read_back(input logic [1:0] ch, input logic pd, input logic wctl);
    logic ack;
    logic [7:0] d, addr;
    logic [9:0] v;
    addr = {QDRB_ADDR_FIXED, pin_hi, pin_lo, 1'b0};
    v = chan[ch];
    if (wctl) begin
      qdrb_master_i.start_cond();
      qdrb_master_i.wbyte(addr, ack);
      `CHK("waddr ack", 1'b1, ack)
      qdrb_master_i.wbyte({5'h00, ch, pd}, ack);
      `CHK("ctrl ack", 1'b1, ack)
      `CHK("ctrl", {5'h00, ch, pd}, ctrl_o)
    end
    qdrb_master_i.start_cond();
    qdrb_master_i.wbyte(addr | 8'h01, ack);
    `CHK("raddr ack", 1'b1, ack)
    `CHK("busy on", 1'b1, busy_o)
    if (pd) begin
      qdrb_master_i.rbyte(1'b1, d);
      `CHK("pd byte", {pmode, QDRB_PD_FILL}, d)
    end
    qdrb_master_i.rbyte(1'b1, d);
    `CHK("high byte", v[9:2], d)
    qdrb_master_i.rbyte(1'b0, d);
    `CHK("low bits", v[1:0], d[7:6])
    qdrb_master_i.stop_cond();
    `CHK("busy", 1'b0, busy_o)
    $display("readback ch %0d pd %0d done", ch, pd);
  endtask
  // reset, each channel with both readback lengths, then a mid-run reset
  initial begin
    reset_check();
    mode_decode();
    for (int k = 0; k < 4; k++) chan[k] = 10'(10'h15A + k * 10'h0D3);
    wrong_addr();
    for (int n = 0; n < 8; n++) begin
      {pin_hi, pin_lo} = 2'(n);
      pmode = 2'(n + 1);
      read_back(2'(n >> 1), n[0], 1'b1);
    end
    // a second reset must bring back channel zero with two bytes
    reset_check();
    read_back(2'h0, 1'b0, 1'b0);
    report_and_stop();
  end
  // a hung bus ends the run well past the expected span
  initial begin
    #2000000;
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
